// ---- src/pdw_dma_top.sv ----
// Parallel DMA word interface: registers, sequencer and user lines
//
// Notes on behaviour
// [R1] Software preloads negative word count first
// [R2] Word count steps only with count gate
// [R3] Count reaching zero stops, sets ready
// [R4] Count/address registers word-only; status byte-or-word
// [R5] Word address register holds 15 bits
// [R6] Address steps only with address gate
// [R7] Address carry bumps the extended bits
// [R8] 16-bit systems wrap address to zero
// [R9] Six-bit extension register only in 22-bit mode
// [R10] Status register per-bit access map
// [R11] Status bits 4-5 read-only in 22-bit mode
// [R12] Shared data buffer address, byte or word
// [R13] User loads input, reads output buffer
// [R14] Data lines mirror buffer bits, high true
// [R15] Three status inputs read as bits 9-11
// [R16] Function outputs driven from bits 1-3
// [R17] Secondary init on init or function 2
// [R18] Byte select low for words, else A0
// [R19] Busy low during bus request or cycle
// [R20] Ready low lets user start transfers
// [R21] Two code inputs select cycle type
// [R22] Burst hold low requests burst operation
// [R23] Request rising edge starts a DMA request
// [R24] Attention stops, sets ready, reads bit 13
// [R25] Address is extension, word address, A0
`timescale 1ns/10ps
`default_nettype none
module pdw_dma_top (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // Register port
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [2:0]  reg_addr_i,
  input  wire logic [1:0]  reg_be_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  output logic             reg_ack_o,
  // Host DMA master side
  output logic             dma_req_o,
  input  wire logic        dma_grant_i,
  output logic             dma_cyc_o,
  output logic      [21:0] dma_addr_o,
  output logic      [1:0]  dma_type_o,
  output logic      [15:0] dma_wdata_o,
  input  wire logic [15:0] dma_rdata_i,
  input  wire logic        dma_done_i,
  input  wire logic        dma_nxm_i,
  output logic             dma_hold_o,
  output logic             irq_req_o,
  // User data lines
  output logic      [15:0] out_data_o,
  input  wire logic [15:0] in_data_i,
  // User control and status lines
  input  wire logic [2:0]  user_status_i,
  output logic      [2:0]  user_function_outputs_o,
  output logic             init_o,
  output logic             secondary_init_output_o,
  input  wire logic        byte_sel_i,
  output logic             busy_o,
  output logic             ready_o,
  input  wire logic [1:0]  cycle_type_code_i,
  input  wire logic        burst_hold_i,
  input  wire logic        cycle_req_i,
  input  wire logic        attention_stop_input_i,
  input  wire logic        count_step_gate_i,
  input  wire logic        address_step_gate_i,
  // Addressing mode straps
  input  wire logic        addr18_mode_i,
  input  wire logic        addr22_mode_i
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  pdw_pkg::pdw_state_t state_r;
  logic [15:0] word_count;
  logic [14:0] bus_address;
  logic [5:0]  ext_bits;
  logic        wc_carry;
  logic        ba_carry;
  logic [15:0] input_buffer_r;
  logic [15:0] output_buffer_r;
  logic [2:0]  func_r;
  logic        ie_r;
  logic        spare8_r;
  logic        spare12_r;
  logic        ready_r;
  logic        nxm_r;
  logic        req_d_r;
  logic [1:0]  cyc_type_r;
  logic        a0_r;
  logic        init_r;
  logic        init2_r;
  logic [15:0] rdata_r;
  logic        ack_r;
  logic        word_acc;
  logic        wr_wc;
  logic        wr_ba;
  logic        wr_csr_lo;
  logic        wr_csr_hi;
  logic        wr_dbr;
  logic        wr_ext;
  logic        go_wr;
  logic        req_rise;
  logic        step;
  logic        stop_evt;
  logic [15:0] csr_view;

  ////////////////////////////////////////////////////////////////////////////
  // Register write decode
  assign word_acc  = reg_wr_i & (&reg_be_i);
  assign wr_wc     = word_acc & (reg_addr_i == pdw_pkg::OFS_WORD_COUNT);    // [R4]
  assign wr_ba     = word_acc & (reg_addr_i == pdw_pkg::OFS_BUS_ADDRESS);   // [R4]
  assign wr_ext    = word_acc & (reg_addr_i == pdw_pkg::OFS_EXT_ADDRESS);   // [R4]
  assign wr_csr_lo = reg_wr_i & reg_be_i[0] & (reg_addr_i == pdw_pkg::OFS_CTRL_STATUS);
  assign wr_csr_hi = reg_wr_i & reg_be_i[1] & (reg_addr_i == pdw_pkg::OFS_CTRL_STATUS);
  assign wr_dbr    = reg_wr_i & (reg_addr_i == pdw_pkg::OFS_DATA_BUFFER);   // [R12]
  assign go_wr     = wr_csr_lo & reg_wdata_i[pdw_pkg::CSR_GO];

  ////////////////////////////////////////////////////////////////////////////
  // Counters
  pdw_step_counter #(
    .W (16)
  ) u_word_count (
    .clk_i      (clk_i),
    .sys_rst_i  (sys_rst_i),
    .load_i     (wr_wc),              // [R1]
    .load_val_i (reg_wdata_i),
    .step_i     (step),
    .gate_i     (count_step_gate_i),  // [R2]
    .count_o    (word_count),
    .carry_o    (wc_carry)
  );

  pdw_step_counter #(
    .W (15)
  ) u_bus_address (
    .clk_i      (clk_i),
    .sys_rst_i  (sys_rst_i),
    .load_i     (wr_ba),
    .load_val_i (reg_wdata_i[15:1]),  // [R5]
    .step_i     (step),
    .gate_i     (address_step_gate_i), // [R6]
    .count_o    (bus_address),
    .carry_o    (ba_carry)
  );

  pdw_ext_addr u_ext_addr (
    .clk_i         (clk_i),
    .sys_rst_i     (sys_rst_i),
    .addr22_mode_i (addr22_mode_i),
    .csr_wr_i      (wr_csr_lo),
    .csr_bits_i    (reg_wdata_i[pdw_pkg::CSR_XA_HI:pdw_pkg::CSR_XA_LO]),
    .ext_wr_i      (wr_ext),
    .ext_val_i     (reg_wdata_i[5:0]),
    .carry_i       (ba_carry),
    .ext_o         (ext_bits)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer events
  assign req_rise = cycle_req_i & ~req_d_r;                                 // [R23]
  assign step     = (state_r == pdw_pkg::PDW_STEP);
  assign stop_evt = wc_carry | attention_stop_input_i;                      // [R3] [R24]

  // Request edge detector
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      req_d_r <= 1'b0;
    else
      req_d_r <= cycle_req_i;
  end

  // DMA sequencer: request bus, run one cycle, then step counters
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      state_r <= pdw_pkg::PDW_IDLE;
    else
    begin
      case (state_r)
        pdw_pkg::PDW_IDLE:
          if (req_rise && !ready_r && !attention_stop_input_i)              // [R24]
            state_r <= pdw_pkg::PDW_REQ;
        pdw_pkg::PDW_REQ:
          if (dma_grant_i)
            state_r <= pdw_pkg::PDW_CYC;
        pdw_pkg::PDW_CYC:
          if (dma_done_i || dma_nxm_i)
            state_r <= pdw_pkg::PDW_STEP;
        pdw_pkg::PDW_STEP:
          state_r <= pdw_pkg::PDW_IDLE;
        default:
          state_r <= pdw_pkg::PDW_IDLE;
      endcase
    end
  end

  // Cycle type and byte select latched with the request
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cyc_type_r <= pdw_pkg::CYC_READ;
      a0_r       <= 1'b0;
    end
    else if (state_r == pdw_pkg::PDW_IDLE && req_rise)
    begin
      cyc_type_r <= cycle_type_code_i;                                      // [R21]
      a0_r       <= byte_sel_i;                                             // [R18]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data buffers
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      input_buffer_r <= pdw_pkg::RST_WORD;
    else if (state_r == pdw_pkg::PDW_IDLE && req_rise)
      input_buffer_r <= in_data_i;                                          // [R13] [R14]
  end

  // Output buffer fed by processor writes or DMA reads
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      output_buffer_r <= pdw_pkg::RST_WORD;
    else if (state_r == pdw_pkg::PDW_CYC && dma_done_i && !cyc_type_r[0])
      output_buffer_r <= dma_rdata_i;                                       // [R13]
    else if (wr_dbr)
    begin
      if (reg_be_i[0])
        output_buffer_r[7:0] <= reg_wdata_i[7:0];                           // [R12]
      if (reg_be_i[1])
        output_buffer_r[15:8] <= reg_wdata_i[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control/status writable fields
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      func_r    <= 3'h0;
      ie_r      <= 1'b0;
      spare8_r  <= 1'b0;
      spare12_r <= 1'b0;
    end
    else
    begin
      if (wr_csr_lo)
      begin
        func_r <= reg_wdata_i[pdw_pkg::CSR_FUNC_HI:pdw_pkg::CSR_FUNC_LO];   // [R10] [R16]
        ie_r   <= reg_wdata_i[pdw_pkg::CSR_IE];
      end
      if (wr_csr_hi)
      begin
        spare8_r  <= reg_wdata_i[pdw_pkg::CSR_SPARE8];                      // [R10]
        spare12_r <= reg_wdata_i[pdw_pkg::CSR_SPARE12];
      end
    end
  end

  // Ready: set by stop events, cleared by a go write; set wins
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      ready_r <= pdw_pkg::RST_READY;
    else if (stop_evt)
      ready_r <= 1'b1;                                                      // [R3] [R24]
    else if (go_wr)
      ready_r <= 1'b0;
  end

  // Bus error flag: only a zero can be written; hardware set wins
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      nxm_r <= 1'b0;
    else if (state_r == pdw_pkg::PDW_CYC && dma_nxm_i)
      nxm_r <= 1'b1;
    else if (wr_csr_hi && !reg_wdata_i[pdw_pkg::CSR_NXM])
      nxm_r <= 1'b0;                                                        // [R10]
  end

  // Read view of the control/status register
  always_comb
  begin
    csr_view                                              = 16'h0000;     // [R10]
    csr_view[pdw_pkg::CSR_FUNC_HI:pdw_pkg::CSR_FUNC_LO]   = func_r;
    csr_view[pdw_pkg::CSR_XA_HI:pdw_pkg::CSR_XA_LO]       = ext_bits[1:0]; // [R11]
    csr_view[pdw_pkg::CSR_IE]                             = ie_r;
    csr_view[pdw_pkg::CSR_READY]                          = ready_r;
    csr_view[pdw_pkg::CSR_SPARE8]                         = spare8_r;
    csr_view[pdw_pkg::CSR_STAT_HI:pdw_pkg::CSR_STAT_LO]   = user_status_i; // [R15]
    csr_view[pdw_pkg::CSR_SPARE12]                        = spare12_r;
    csr_view[pdw_pkg::CSR_ATTENTION_STOP_INPUT]                           = attention_stop_input_i; // [R24]
    csr_view[pdw_pkg::CSR_NXM]                            = nxm_r;
    csr_view[pdw_pkg::CSR_ERROR]                          = nxm_r | attention_stop_input_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read data and acknowledge, one cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rdata_r <= pdw_pkg::RST_WORD;
      ack_r   <= 1'b0;
    end
    else
    begin
      ack_r <= reg_rd_i | reg_wr_i;
      if (reg_rd_i)
      begin
        case (reg_addr_i)
          pdw_pkg::OFS_WORD_COUNT:  rdata_r <= word_count;
          pdw_pkg::OFS_BUS_ADDRESS: rdata_r <= {bus_address, 1'b0};         // [R5]
          pdw_pkg::OFS_CTRL_STATUS: rdata_r <= csr_view;
          pdw_pkg::OFS_DATA_BUFFER: rdata_r <= input_buffer_r;              // [R12]
          pdw_pkg::OFS_EXT_ADDRESS: rdata_r <= addr22_mode_i ? {10'h000, ext_bits} : 16'h0000; // [R9]
          default:                  rdata_r <= 16'h0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Init outputs: secondary follows init or a one written to function 2
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      init_r  <= 1'b1;
      init2_r <= 1'b1;
    end
    else
    begin
      init_r  <= 1'b0;
      init2_r <= wr_csr_lo & reg_wdata_i[pdw_pkg::CSR_FUNC_2];              // [R17]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host side outputs
  assign dma_req_o  = (state_r == pdw_pkg::PDW_REQ);
  assign dma_cyc_o  = (state_r == pdw_pkg::PDW_CYC);
  assign dma_type_o = cyc_type_r;
  assign dma_hold_o = ~burst_hold_i & ~ready_r;                             // [R22]
  assign irq_req_o  = ie_r & ready_r;                                       // [R3]
  assign dma_wdata_o = input_buffer_r;

  // Full address; 16-bit systems drop the extension so it wraps to zero
  always_comb
  begin
    if (addr22_mode_i)
      dma_addr_o = {ext_bits, bus_address, a0_r};                           // [R25]
    else if (addr18_mode_i)
      dma_addr_o = {4'h0, ext_bits[1:0], bus_address, a0_r};                // [R25]
    else
      dma_addr_o = {6'h00, bus_address, a0_r};                              // [R8]
  end

  ////////////////////////////////////////////////////////////////////////////
  // User side and register port outputs
  assign busy_o      = ~(dma_req_o | dma_cyc_o);                           // [R19]
  assign ready_o     = ready_r;                                            // [R20]
  assign out_data_o  = output_buffer_r;                                    // [R14]
  assign user_function_outputs_o = func_r;                                 // [R16]
  assign init_o      = init_r;
  assign secondary_init_output_o = init_r | init2_r;                       // [R17]
  assign reg_rdata_o = rdata_r;
  assign reg_ack_o   = ack_r;

endmodule
`default_nettype wire

// ---- src/pdw_pkg.sv ----
// Shared constants and types for the parallel DMA word interface
package pdw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register word offsets on the register port
  localparam logic [2:0] OFS_WORD_COUNT  = 3'h0;
  localparam logic [2:0] OFS_BUS_ADDRESS = 3'h1;
  localparam logic [2:0] OFS_CTRL_STATUS = 3'h2;
  localparam logic [2:0] OFS_DATA_BUFFER = 3'h3;
  localparam logic [2:0] OFS_EXT_ADDRESS = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Control/status field positions
  localparam int CSR_GO      = 0;
  localparam int CSR_FUNC_LO = 1;
  localparam int CSR_FUNC_2  = 2;
  localparam int CSR_FUNC_HI = 3;
  localparam int CSR_XA_LO   = 4;
  localparam int CSR_XA_HI   = 5;
  localparam int CSR_IE      = 6;
  localparam int CSR_READY   = 7;
  localparam int CSR_SPARE8  = 8;
  localparam int CSR_STAT_LO = 9;
  localparam int CSR_STAT_HI = 11;
  localparam int CSR_SPARE12 = 12;
  localparam int CSR_ATTENTION_STOP_INPUT    = 13;
  localparam int CSR_NXM     = 14;
  localparam int CSR_ERROR   = 15;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [15:0] RST_WORD   = 16'h0000;
  localparam logic [5:0]  RST_EXT    = 6'h00;
  localparam logic        RST_READY  = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycle codes, first code bit in bit 1
  localparam logic [1:0] CYC_READ       = 2'h0;
  localparam logic [1:0] CYC_READ_MOD_W = 2'h2;
  localparam logic [1:0] CYC_WORD_WRITE = 2'h1;
  localparam logic [1:0] CYC_BYTE_WRITE = 2'h3;

  // DMA sequencer states
  typedef enum logic [1:0] {PDW_IDLE, PDW_REQ, PDW_CYC, PDW_STEP} pdw_state_t;

endpackage

// ---- src/pdw_step_counter.sv ----
// Loadable up-counter with a gated step and a carry out
`timescale 1ns/10ps
`default_nettype none
module pdw_step_counter #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  // Software load
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  // Hardware step
  input  wire logic         step_i,
  input  wire logic         gate_i,
  // Count and carry
  output logic      [W-1:0] count_o,
  output logic              carry_o
);

  logic [W-1:0] count_r;

  // Load from software, else step only while the gate is high
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      count_r <= '0;
    else if (load_i)
      count_r <= load_val_i;
    else if (step_i && gate_i)
      count_r <= count_r + 1'b1;
  end

  assign count_o = count_r;
  // Carry when an enabled step rolls the count over
  assign carry_o = step_i & gate_i & (&count_r);

endmodule
`default_nettype wire

// ---- src/pdw_ext_addr.sv ----
// Extended address bits, two in 18-bit mode, six in 22-bit mode
`timescale 1ns/10ps
`default_nettype none
module pdw_ext_addr (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // Mode
  input  wire logic       addr22_mode_i,
  // Software writes
  input  wire logic       csr_wr_i,
  input  wire logic [1:0] csr_bits_i,
  input  wire logic       ext_wr_i,
  input  wire logic [5:0] ext_val_i,
  // Carry from the word address
  input  wire logic       carry_i,
  // Extended bits
  output logic      [5:0] ext_o
);

  logic [5:0] ext_r;

  // Carry bumps all six bits in 22-bit mode, else only the low two
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      ext_r <= pdw_pkg::RST_EXT;
    else if (carry_i && addr22_mode_i)
      ext_r <= ext_r + 6'h01;                         // [R7]
    else if (carry_i)
      ext_r[1:0] <= ext_r[1:0] + 2'h1;                // [R7]
    else if (ext_wr_i && addr22_mode_i)
      ext_r <= ext_val_i;                             // [R9]
    else if (csr_wr_i && !addr22_mode_i)
      ext_r[1:0] <= csr_bits_i;                       // [R11]
  end

  assign ext_o = ext_r;

endmodule
`default_nettype wire

// ---- verification/pdw_dma_top_props.sv ----
// Port assertions for the parallel DMA word interface
`timescale 1ns/10ps
`default_nettype none
module pdw_dma_top_props (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  // Register port
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic        reg_ack_o,
  // Host DMA side
  input wire logic        dma_req_o,
  input wire logic        dma_grant_i,
  input wire logic        dma_cyc_o,
  input wire logic        dma_done_i,
  input wire logic        dma_nxm_i,
  input wire logic [21:0] dma_addr_o,
  input wire logic        dma_hold_o,
  input wire logic        irq_req_o,
  // User lines and straps
  input wire logic        init_o,
  input wire logic        secondary_init_output_o,
  input wire logic        busy_o,
  input wire logic        ready_o,
  input wire logic        burst_hold_i,
  input wire logic        cycle_req_i,
  input wire logic        attention_stop_input_i,
  input wire logic        addr18_mode_i,
  input wire logic        addr22_mode_i
);
  ////////////////////////////////////////////////////////////////////////////
  // Single clock domain
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // Transfer steps
  sequence s_edge;
    $rose(cycle_req_i) && !ready_o && !attention_stop_input_i && busy_o && !$past(dma_cyc_o);
  endsequence
  sequence s_end;
    dma_cyc_o && (dma_done_i || dma_nxm_i);
  endsequence
  sequence s_step;
    busy_o && !dma_cyc_o ##1 busy_o && !dma_req_o;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // Properties
  property p_start;
    s_edge |=> dma_req_o && !busy_o;
  endproperty
  a_start: assert property (p_start) else $error("start");
  property p_grant;
    dma_req_o && dma_grant_i |=> dma_cyc_o && !dma_req_o;
  endproperty
  a_grant: assert property (p_grant) else $error("grant");
  property p_end;
    s_end |=> s_step;
  endproperty
  a_end: assert property (p_end) else $error("end");
  property p_busy;
    busy_o == !(dma_req_o || dma_cyc_o);
  endproperty
  a_busy: assert property (p_busy) else $error("busy");
  property p_stop;
    attention_stop_input_i |=> ready_o;
  endproperty
  a_stop: assert property (p_stop) else $error("stop");
  property p_irq;
    irq_req_o |-> ready_o;
  endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_hold;
    dma_hold_o == (!burst_hold_i && !ready_o);
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_init;
    init_o |-> secondary_init_output_o;
  endproperty
  a_init: assert property (p_init) else $error("init");
  property p_ack;
    reg_wr_i || reg_rd_i |=> reg_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack");
  property p_wrap;
    dma_cyc_o && !addr18_mode_i && !addr22_mode_i |-> dma_addr_o[21:16] == 6'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap");
  property p_q18;
    dma_cyc_o && addr18_mode_i && !addr22_mode_i |-> dma_addr_o[21:18] == 4'h0;
  endproperty
  a_q18: assert property (p_q18) else $error("q18");
endmodule

bind pdw_dma_top pdw_dma_top_props u_props (.*);
`default_nettype wire

// ---- verification/pdw_user_dev.sv ----
// Behavioural model of the user's parallel device
`timescale 1ns/10ps
`default_nettype none
module pdw_user_dev (
  // Clock
  input  wire logic        clk_i,
  // Lines from the interface
  input  wire logic        busy_i,
  input  wire logic        ready_i,
  // Lines to the interface
  output logic             cycle_req_o,
  output logic      [1:0]  code_o,
  output logic             a0_o,
  output logic      [15:0] data_o
);
  // Quiet lines at start
  initial
  begin
    {cycle_req_o, code_o, a0_o, data_o} = 20'h00000;
  end

  // One transfer
  task automatic xfer(input logic [1:0] c, input logic a0, input logic [15:0] d, output logic ok);
    int n;
    ok = 1'h0;
    @(posedge clk_i) #1;
    if (ready_i !== 1'h0)
      return;
    code_o = c;
    a0_o = a0;
    data_o = d;
    cycle_req_o = 1'h1;
    for (n = 0; n < 50 && busy_i !== 1'h0; n++) @(posedge clk_i) #1;
    for (; n < 100 && busy_i !== 1'h1; n++) @(posedge clk_i) #1;
    ok = (n < 100);
    @(posedge clk_i) #1;
    cycle_req_o = 1'h0;
    a0_o = 1'h0;
    data_o = ~d;
    code_o = ~c;
  endtask

  // Refused request edge
  task automatic poke();
    @(posedge clk_i) #1;
    cycle_req_o = 1'h1;
    repeat (4) @(posedge clk_i);
    #1;
    cycle_req_o = 1'h0;
  endtask
endmodule
`default_nettype wire

// ---- verification/pdw_dma_top_tb.sv ----
// Self-checking testbench for the parallel DMA word interface
`timescale 1ns/10ps
`default_nettype none
module pdw_dma_top_tb;
  ////////////////////////////////////////////////////////////////////////////
  // Design lines, captures and counters
  logic        clk_i = 1'h0;
  logic        sys_rst_i, reg_wr_i, reg_rd_i, reg_ack_o, dma_req_o, dma_cyc_o, dma_nxm_i, dma_hold_o;
  logic        dma_grant_i = 1'h0;
  logic        dma_done_i = 1'h0;
  logic        irq_req_o, init_o, secondary_init_output_o, byte_sel_i, busy_o, ready_o, burst_hold_i;
  logic        cycle_req_i, attention_stop_input_i, count_step_gate_i, address_step_gate_i;
  logic        addr18_mode_i, addr22_mode_i;
  logic [1:0]  reg_be_i, dma_type_o, cycle_type_code_i, cap_type;
  logic [2:0]  reg_addr_i, user_status_i, user_function_outputs_o;
  logic [15:0] reg_wdata_i, reg_rdata_o, dma_wdata_o, dma_rdata_i, out_data_o, in_data_i, cap_wd;
  logic [21:0] dma_addr_o, cap_addr;
  int          n_errors, checks_done;
  localparam logic [2:0] A_WC = pdw_pkg::OFS_WORD_COUNT;
  localparam logic [2:0] A_BA = pdw_pkg::OFS_BUS_ADDRESS;
  localparam logic [2:0] A_CS = pdw_pkg::OFS_CTRL_STATUS;
  localparam logic [2:0] A_DB = pdw_pkg::OFS_DATA_BUFFER;
  localparam logic [2:0] A_XA = pdw_pkg::OFS_EXT_ADDRESS;

  // Design, user device model and clock
  pdw_dma_top u_dut (.*);
  pdw_user_dev u_dev (.clk_i, .busy_i(busy_o), .ready_i(ready_o), .cycle_req_o(cycle_req_i),
    .code_o(cycle_type_code_i), .a0_o(byte_sel_i), .data_o(in_data_i));
  always #2 clk_i = ~clk_i;

  // Host bus model
  always @(posedge clk_i)
  begin
    #1;
    dma_grant_i = dma_req_o;
    dma_done_i = dma_cyc_o;
    if (dma_cyc_o) {cap_addr, cap_type, cap_wd} = {dma_addr_o, dma_type_o, dma_wdata_o};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [1:0] be, input logic [15:0] d);
    @(posedge clk_i) #1;
    {reg_wr_i, reg_addr_i, reg_be_i, reg_wdata_i} = {1'h1, a, be, d};
    @(posedge clk_i) #1;
    reg_wr_i = 1'h0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    @(posedge clk_i) #1;
    {reg_rd_i, reg_addr_i} = {1'h1, a};
    @(posedge clk_i) #1;
    reg_rd_i = 1'h0;
    chk(reg_rdata_o, exp);
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic xfer(input logic [1:0] c, input logic a0, input logic [15:0] d);
    logic ok;
    u_dev.xfer(c, a0, d, ok);
    chk(ok, 1'h1);
    if (!ok)
      end_of_test();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    chk(ready_o, 1'h1);
    rd(A_CS, 16'h0A80);
    rd(3'h5, 16'h0000);
    chk(init_o, 1'h0);
    $display("reset test done");
  endtask
  task automatic t_csr();
    wr(A_CS, 2'h3, 16'hFFFF);
    chk(secondary_init_output_o, 1'h1);
    rd(A_CS, 16'h1B7E);
    chk(user_function_outputs_o, 3'h7);
    chk(secondary_init_output_o, 1'h0);
    wr(A_CS, 2'h2, 16'h0000);
    rd(A_CS, 16'h0A7E);
    wr(A_WC, 2'h1, 16'h1234);
    rd(A_WC, 16'h0000);
    $display("control register test done");
  endtask
  task automatic t_dma();
    wr(A_WC, 2'h3, 16'hFFFE);
    wr(A_BA, 2'h3, 16'hFFFE);
    wr(A_CS, 2'h3, 16'h0001);
    burst_hold_i = 1'h0;
    xfer(pdw_pkg::CYC_WORD_WRITE, 1'h0, 16'h1234);
    chk(cap_addr, 22'h00FFFE);
    chk({cap_type, cap_wd}, {pdw_pkg::CYC_WORD_WRITE, 16'h1234});
    xfer(pdw_pkg::CYC_BYTE_WRITE, 1'h1, 16'h0F0F);
    chk(cap_addr, 22'h010001);
    chk(cap_type, pdw_pkg::CYC_BYTE_WRITE);
    rd(A_WC, 16'h0000);
    chk(ready_o, 1'h1);
    rd(A_CS, 16'h0A90);
    rd(A_BA, 16'h0002);
    burst_hold_i = 1'h1;
    $display("transfer test done");
  endtask
  task automatic t_gates();
    wr(A_WC, 2'h3, 16'hFFFF);
    wr(A_BA, 2'h3, 16'h0010);
    wr(A_CS, 2'h3, 16'h0001);
    {count_step_gate_i, address_step_gate_i} = 2'h0;
    xfer(pdw_pkg::CYC_READ, 1'h0, 16'h2222);
    chk({cap_type, cap_addr}, {pdw_pkg::CYC_READ, 22'h000010});
    chk(out_data_o, 16'hBEEF);
    rd(A_WC, 16'hFFFF);
    rd(A_BA, 16'h0010);
    chk(ready_o, 1'h0);
    {count_step_gate_i, address_step_gate_i} = 2'h3;
    xfer(pdw_pkg::CYC_READ_MOD_W, 1'h0, 16'h3333);
    chk(cap_type, pdw_pkg::CYC_READ_MOD_W);
    rd(A_BA, 16'h0012);
    chk(ready_o, 1'h1);
    $display("step gate test done");
  endtask
  task automatic t_buffers();
    wr(A_DB, 2'h3, 16'hA5C3);
    chk(out_data_o, 16'hA5C3);
    wr(A_DB, 2'h1, 16'h0011);
    chk(out_data_o, 16'hA511);
    rd(A_DB, 16'h3333);
    $display("data buffer test done");
  endtask
  task automatic t_attention_stop_input();
    wr(A_CS, 2'h3, 16'h0041);
    chk(irq_req_o, 1'h0);
    attention_stop_input_i = 1'h1;
    repeat (2) @(posedge clk_i);
    #1;
    chk({ready_o, irq_req_o}, 2'h3);
    rd(A_CS, 16'hAAC0);
    u_dev.poke();
    rd(A_WC, 16'h0000);
    attention_stop_input_i = 1'h0;
    $display("attention test done");
  endtask
  task automatic t_modes();
    wr(A_XA, 2'h3, 16'h002A);
    rd(A_XA, 16'h0000);
    {addr18_mode_i, addr22_mode_i} = 2'h1;
    wr(A_XA, 2'h3, 16'h002A);
    wr(A_XA, 2'h1, 16'h0015);
    rd(A_XA, 16'h002A);
    wr(A_CS, 2'h3, 16'h0031);
    rd(A_XA, 16'h002A);
    xfer(pdw_pkg::CYC_WORD_WRITE, 1'h0, 16'h4444);
    chk(cap_addr, 22'h2A0012);
    addr22_mode_i = 1'h0;
    xfer(pdw_pkg::CYC_WORD_WRITE, 1'h0, 16'h5555);
    chk(cap_addr, 22'h000014);
    $display("address mode test done");
  endtask

  // Main sequence
  initial
  begin
    n_errors = 0;
    checks_done = 0;
    sys_rst_i = 1'h1;
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_be_i, reg_wdata_i} = 23'h000000;
    {dma_nxm_i, attention_stop_input_i, addr22_mode_i} = 3'h0;
    {burst_hold_i, count_step_gate_i, address_step_gate_i, addr18_mode_i} = 4'hF;
    dma_rdata_i = 16'hBEEF;
    user_status_i = 3'h5;
    repeat (20) @(posedge clk_i);
    #1;
    chk(init_o, 1'h1);
    sys_rst_i = 1'h0;
    t_reset();
    t_csr();
    t_dma();
    t_gates();
    t_buffers();
    t_attention_stop_input();
    t_modes();
    end_of_test();
  end
endmodule
`default_nettype wire
